/* llpc_line_loopback.sv */
`timescale 1ns/1ps

module llpc_line_loopback #(
  parameter int HOLD_CYCLES = llpc_pkg::HOLD_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // loop controls
  input wire logic analog_loop_enable,
  input wire logic remote_loop_enable,
  input wire logic digital_loop_enable,
  input wire logic auto_loop_enable,
  input wire logic detector_place_select,
  // inband code detector levels, on the placed path
  input wire logic inband_code_act,
  input wire logic inband_code_deact,
  // line bit rate enable
  input wire logic bit_en,
  // data sources
  input wire logic rx_line_data,
  input wire logic tx_sys_data,
  // diagnostic generators
  input wire logic rx_pat_gen_en,
  input wire logic rx_pat_gen_data,
  input wire logic rx_ais_gen_en,
  input wire logic tx_pat_gen_en,
  input wire logic tx_pat_gen_data,
  input wire logic tx_ais_gen_en,
  // steered data
  output logic rx_sys_data,
  output logic tx_line_data,
  // detector feeds
  output logic rx_err_det_data,
  output logic rx_los_det_data,
  output logic tx_det_data,
  output logic pattern_det_data,
  // mode and status
  output logic analog_active,
  output logic remote_active,
  output logic digital_active,
  output logic tx_clock_ignore,
  output logic auto_loop_active_flag,
  output logic [llpc_pkg::STATUS_REG0_W-1:0] status_reg0
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic pick(input logic sel, input logic a,
                                input logic b);
    pick = sel ? a : b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // automatic loop state machine

  localparam logic [llpc_pkg::HOLD_W-1:0] HOLD_LAST =
    llpc_pkg::HOLD_W'(HOLD_CYCLES - 1);

  llpc_pkg::llpc_auto_state_t auto_q;
  llpc_pkg::llpc_auto_state_t auto_d;
  logic [llpc_pkg::HOLD_W-1:0] hold_q;
  logic type_q;
  logic hold_done;
  logic auto_rem;
  logic auto_dig;
  logic arm_ok;

  assign hold_done = hold_q == HOLD_LAST;
  // auto remote cannot arm under manual digital or analog
  assign arm_ok = !analog_loop_enable &&
    (detector_place_select == llpc_pkg::PLACE_TX ||
     !digital_loop_enable);

  always_comb begin
    auto_d = auto_q;
    case (auto_q)
      llpc_pkg::AUTO_IDLE: begin
        if (inband_code_act && arm_ok) begin
          auto_d = llpc_pkg::AUTO_ARM;
        end
      end
      llpc_pkg::AUTO_ARM: begin
        if (!inband_code_act || !arm_ok) begin
          auto_d = llpc_pkg::AUTO_IDLE;
        end else if (hold_done) begin
          auto_d = llpc_pkg::AUTO_LOOPED;
        end
      end
      llpc_pkg::AUTO_LOOPED: begin
        if (inband_code_deact) begin
          auto_d = llpc_pkg::AUTO_DISARM;
        end
      end
      llpc_pkg::AUTO_DISARM: begin
        if (!inband_code_deact) begin
          auto_d = llpc_pkg::AUTO_LOOPED;
        end else if (hold_done) begin
          auto_d = llpc_pkg::AUTO_IDLE;
        end
      end
      default: auto_d = llpc_pkg::AUTO_IDLE;
    endcase
    // disabling auto, or manual digital under auto remote, drops it
    if (!auto_loop_enable) begin
      auto_d = llpc_pkg::AUTO_IDLE;
    end else if (auto_rem && digital_loop_enable) begin
      auto_d = llpc_pkg::AUTO_IDLE;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      auto_q <= llpc_pkg::AUTO_IDLE;
    end else begin
      auto_q <= auto_d;
    end
  end

  // counter restarts on every state change, so each hold is timed afresh
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_q <= '0;
    end else if (auto_d != auto_q || hold_done) begin
      hold_q <= '0;
    end else if (auto_q == llpc_pkg::AUTO_ARM ||
                 auto_q == llpc_pkg::AUTO_DISARM) begin
      hold_q <= hold_q + 1'b1;
    end
  end

  // loop type latched at arming; placement must not move meanwhile
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      type_q <= llpc_pkg::PLACE_RX;
    end else if (auto_q == llpc_pkg::AUTO_IDLE) begin
      type_q <= detector_place_select;
    end
  end

  assign auto_loop_active_flag = auto_q == llpc_pkg::AUTO_LOOPED ||
    auto_q == llpc_pkg::AUTO_DISARM;
  assign auto_rem = auto_loop_active_flag && type_q == llpc_pkg::PLACE_RX;
  assign auto_dig = auto_loop_active_flag && type_q == llpc_pkg::PLACE_TX;

  ////////////////////////////////////////////////////////////////////////
  // effective loop modes

  assign analog_active = analog_loop_enable;
  assign remote_active = !analog_loop_enable &&
    (remote_loop_enable || auto_rem);
  assign digital_active = !analog_loop_enable &&
    (digital_loop_enable || auto_dig);
  assign tx_clock_ignore = remote_active;

  ////////////////////////////////////////////////////////////////////////
  // path steering

  logic tx_line_d;
  logic rx_sys_d;
  logic rx_in;
  logic dual;

  assign dual = remote_active && digital_active;

  always_comb begin
    if (dual) begin
      // auto dual drops tx pattern; manual dual puts looped above it
      tx_line_d = rx_line_data;
    end else if (remote_active) begin
      tx_line_d = pick(tx_pat_gen_en, tx_pat_gen_data,
                       rx_line_data);
    end else if (digital_active || analog_active) begin
      // data always present, so AIS below data never reaches the line
      tx_line_d = pick(tx_pat_gen_en, tx_pat_gen_data,
                       tx_sys_data);
    end else begin
      tx_line_d = pick(tx_pat_gen_en, tx_pat_gen_data,
                       pick(tx_ais_gen_en, llpc_pkg::AIS_LEVEL,
                            tx_sys_data));
    end
  end

  // analog loop takes the shaper input, not the line
  assign rx_in = analog_active ? tx_line_d : rx_line_data;

  always_comb begin
    if (digital_active) begin
      rx_sys_d = pick(rx_pat_gen_en, rx_pat_gen_data,
                      tx_sys_data);
    end else if (analog_active) begin
      rx_sys_d = pick(rx_pat_gen_en, rx_pat_gen_data, rx_in);
    end else begin
      rx_sys_d = pick(rx_pat_gen_en, rx_pat_gen_data,
                      pick(rx_ais_gen_en, llpc_pkg::AIS_LEVEL,
                           rx_line_data));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs, data and detector feeds advanced on the bit enable, status every clock

  logic rx_err_d;

  assign rx_err_d = digital_active ? tx_sys_data : rx_in;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_sys_data <= llpc_pkg::DATA_RESET;
      tx_line_data <= llpc_pkg::DATA_RESET;
    end else if (bit_en) begin
      rx_sys_data <= rx_sys_d;
      tx_line_data <= tx_line_d;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_err_det_data <= llpc_pkg::DATA_RESET;
      rx_los_det_data <= llpc_pkg::DATA_RESET;
      tx_det_data <= llpc_pkg::DATA_RESET;
      pattern_det_data <= llpc_pkg::DATA_RESET;
    end else if (bit_en) begin
      rx_err_det_data <= rx_err_d;
      rx_los_det_data <= rx_in;
      tx_det_data <= tx_sys_data;
      pattern_det_data <= pick(detector_place_select == llpc_pkg::PLACE_TX,
                               tx_sys_data, rx_err_d);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_reg0 <= llpc_pkg::STATUS_REG0_RESET;
    end else begin
      status_reg0 <= llpc_pkg::STATUS_REG0_RESET;
      status_reg0[llpc_pkg::STATUS_REG0_AUTO_BIT] <=
        auto_loop_active_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_act_held;
    auto_q == llpc_pkg::AUTO_ARM && inband_code_act && hold_done;
  endsequence

  sequence s_deact_held;
    auto_q == llpc_pkg::AUTO_DISARM && inband_code_deact && hold_done;
  endsequence

  a_analog_forces_off: assert property (
    analog_loop_enable |-> !remote_active && !digital_active)
    else $error("loop active under analog loopback");

  a_analog_rx_loop: assert property (
    bit_en && analog_active && !rx_pat_gen_en
    |=> rx_sys_data == $past(tx_line_d))
    else $error("analog loop rx not looped tx");

  a_auto_entry: assert property (
    s_act_held and (auto_loop_enable && arm_ok
    && !(auto_rem && digital_loop_enable)) |=> auto_loop_active_flag)
    else $error("auto loop not entered after hold");

  a_auto_leave: assert property (
    s_deact_held and auto_loop_enable |=> !auto_loop_active_flag)
    else $error("auto loop not left after hold");

  a_auto_rise_cause: assert property (
    $rose(auto_loop_active_flag) |-> $past(hold_q) == HOLD_LAST
    && $past(inband_code_act))
    else $error("auto loop entered early");

  a_auto_clear: assert property (
    !auto_loop_enable |=> !auto_loop_active_flag)
    else $error("auto loop survived enable clear");

  a_status_bit: assert property (
    ##1 status_reg0[llpc_pkg::STATUS_REG0_AUTO_BIT] ==
    $past(auto_loop_active_flag))
    else $error("status bit does not track auto loop");

  a_remote_tx: assert property (
    bit_en && remote_active && !digital_active && !tx_pat_gen_en
    |=> tx_line_data == $past(rx_line_data))
    else $error("remote loop tx not line data");

  a_tx_det_sys: assert property (
    bit_en |=> tx_det_data == $past(tx_sys_data))
    else $error("tx detectors not on system data");

  a_digital_rx: assert property (
    bit_en && digital_active && !rx_pat_gen_en
    |=> rx_sys_data == $past(tx_sys_data) &&
    rx_los_det_data == $past(rx_line_data))
    else $error("digital loop rx steering wrong");

  a_dual_tx: assert property (
    bit_en && dual |=> tx_line_data == $past(rx_line_data) &&
    rx_err_det_data == $past(tx_sys_data))
    else $error("dual loop steering wrong");

  a_no_auto_rem_dig: assert property (
    ##1 auto_rem |-> !$past(digital_loop_enable) || $past(auto_rem) == 1'b0
    || !digital_loop_enable || auto_q != llpc_pkg::AUTO_LOOPED)
    else $error("auto remote kept under digital loop");

endmodule // llpc_line_loopback

/* llpc_pkg.sv */
package llpc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // loop control bit positions and placement encodings

  localparam int LOOP_ANALOG_BIT = 0;
  localparam int LOOP_REMOTE_BIT = 1;
  localparam int LOOP_DIGITAL_BIT = 2;
  localparam int LOOP_AUTO_BIT = 3;
  localparam logic PLACE_RX = 1'b0;
  localparam logic PLACE_TX = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // status register 0 layout

  localparam int STATUS_REG0_W = 8;
  localparam int STATUS_REG0_AUTO_BIT = 7;
  localparam logic [7:0] STATUS_REG0_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // data levels

  localparam logic AIS_LEVEL = 1'b1;
  localparam logic DATA_RESET = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // inband code persistence timing

  localparam int CLK_HZ = 20000000;
  localparam int HOLD_TIME_MS = 5100;
  localparam int HOLD_CYC = HOLD_TIME_MS * (CLK_HZ / 1000);
  localparam int HOLD_W = 27;

  ////////////////////////////////////////////////////////////////////////
  // automatic loop states

  typedef enum logic [3:0] {
    AUTO_IDLE = 4'b0001,
    AUTO_ARM = 4'b0010,
    AUTO_LOOPED = 4'b0100,
    AUTO_DISARM = 4'b1000
  } llpc_auto_state_t;

endpackage

/* llpc_far_end_model.sv */
`timescale 1ns/1ps

// framer and line seen as one far end: one bit slot per call
module llpc_far_end_model (
  // clock
  input wire logic clk,
  // slot strobe and data toward the block
  output logic bit_en,
  output logic rx_line_data,
  output logic tx_sys_data
);

  initial begin
    bit_en = 1'b0;
    rx_line_data = 1'b0;
    tx_sys_data = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // data flips once the slot closes, so a stray sample shows up
  task automatic send_slot(input logic rx_bit, input logic tx_bit);
    @(posedge clk);
    #1;
    bit_en = 1'b1;
    rx_line_data = rx_bit;
    tx_sys_data = tx_bit;
    @(posedge clk);
    #1;
    bit_en = 1'b0;
    rx_line_data = ~rx_bit;
    tx_sys_data = ~tx_bit;
  endtask

endmodule // llpc_far_end_model

/* llpc_line_loopback_tb_top.sv */
`timescale 1ns/1ps

module llpc_line_loopback_tb_top;
  localparam int HOLD = 4;
  localparam int LIMIT = 3000;
  logic clk, reset, bit_en, rx_line_data, tx_sys_data, auto_on;
  logic analog_loop_enable, remote_loop_enable, digital_loop_enable;
  logic auto_loop_enable, detector_place_select;
  logic inband_code_act, inband_code_deact;
  logic rx_pat_gen_en, rx_pat_gen_data, rx_ais_gen_en;
  logic tx_pat_gen_en, tx_pat_gen_data, tx_ais_gen_en;
  logic rx_sys_data, tx_line_data, rx_err_det_data, rx_los_det_data;
  logic tx_det_data, pattern_det_data, analog_active, remote_active;
  logic digital_active, tx_clock_ignore, auto_loop_active_flag;
  logic [llpc_pkg::STATUS_REG0_W-1:0] status_reg0;
  logic [12:0] ctl;
  logic [15:0] s;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;

  assign {analog_loop_enable, remote_loop_enable, digital_loop_enable,
          auto_loop_enable, detector_place_select, inband_code_act,
          inband_code_deact, rx_pat_gen_en, rx_pat_gen_data, rx_ais_gen_en,
          tx_pat_gen_en, tx_pat_gen_data, tx_ais_gen_en} = ctl;

  always #25 clk = ~clk;

  llpc_far_end_model i_far (.clk(clk), .bit_en(bit_en),
    .rx_line_data(rx_line_data), .tx_sys_data(tx_sys_data));

  llpc_line_loopback #(.HOLD_CYCLES(HOLD)) i_dut (.clk(clk), .reset(reset),
    .analog_loop_enable(analog_loop_enable),
    .remote_loop_enable(remote_loop_enable),
    .digital_loop_enable(digital_loop_enable),
    .auto_loop_enable(auto_loop_enable),
    .detector_place_select(detector_place_select),
    .inband_code_act(inband_code_act), .inband_code_deact(inband_code_deact),
    .bit_en(bit_en), .rx_line_data(rx_line_data), .tx_sys_data(tx_sys_data),
    .rx_pat_gen_en(rx_pat_gen_en), .rx_pat_gen_data(rx_pat_gen_data),
    .rx_ais_gen_en(rx_ais_gen_en), .tx_pat_gen_en(tx_pat_gen_en),
    .tx_pat_gen_data(tx_pat_gen_data), .tx_ais_gen_en(tx_ais_gen_en),
    .rx_sys_data(rx_sys_data), .tx_line_data(tx_line_data),
    .rx_err_det_data(rx_err_det_data), .rx_los_det_data(rx_los_det_data),
    .tx_det_data(tx_det_data), .pattern_det_data(pattern_det_data),
    .analog_active(analog_active), .remote_active(remote_active),
    .digital_active(digital_active), .tx_clock_ignore(tx_clock_ignore),
    .auto_loop_active_flag(auto_loop_active_flag),
    .status_reg0(status_reg0));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // {rx_sys, tx_line, rx_err, rx_los, pattern_det}
  function automatic logic [4:0] steer(logic r, logic d, logic rb, logic tb);
    logic tl, rs, re, rl;
    tl = tx_pat_gen_en ? tx_pat_gen_data : tx_ais_gen_en ? 1'b1 : tb;
    rs = rx_pat_gen_en ? rx_pat_gen_data : rx_ais_gen_en ? 1'b1 : rb;
    re = rb;
    rl = rb;
    if (analog_loop_enable) begin
      tl = tx_pat_gen_en ? tx_pat_gen_data : tb;
      rs = rx_pat_gen_en ? rx_pat_gen_data : tl;
      re = tl;
      rl = tl;
    end else if (r && d) begin
      // remote loop wins the line; tx pattern has no way out
      tl = rb;
      rs = rx_pat_gen_en ? rx_pat_gen_data : tb;
      re = tb;
    end else if (r) begin
      tl = tx_pat_gen_en ? tx_pat_gen_data : rb;
    end else if (d) begin
      tl = tx_pat_gen_en ? tx_pat_gen_data : tb;
      rs = rx_pat_gen_en ? rx_pat_gen_data : tb;
      re = tb;
    end
    return {rs, tl, re, rl, detector_place_select ? tb : re};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one slot, then an idle edge: outputs must still hold the slot's bits
  task automatic run_slot(input logic rb, input logic tb);
    logic er, ed;
    logic [4:0] want;
    logic [7:0] got;
    er = ~ctl[12] & (ctl[11] | (auto_on & ~ctl[8]));
    ed = ~ctl[12] & (ctl[10] | (auto_on & ctl[8]));
    want = steer(er, ed, rb, tb);
    i_far.send_slot(rb, tb);
    cycles(1);
    got = {3'h0, rx_sys_data, tx_line_data, rx_err_det_data,
           rx_los_det_data, pattern_det_data};
    check_byte(got, {3'h0, want});
    check_bit(rx_sys_data, want[4]);
    check_bit(rx_err_det_data, want[2]);
    check_bit(analog_active, ctl[12]);
    check_bit(remote_active, er);
    check_bit(digital_active, ed);
    check_bit(tx_clock_ignore, er);
    check_bit(tx_det_data, tb);
  endtask

  // flag moves on the fifth edge after the code appears
  task automatic hold_code(input logic [1:0] code, input logic flag_exp);
    ctl[7:6] = code;
    cycles(HOLD);
    check_bit(auto_loop_active_flag, ~flag_exp);
    cycles(1);
    check_bit(auto_loop_active_flag, flag_exp);
    ctl[7:6] = 2'b00;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    ctl = 13'h0000;
    auto_on = 1'b0;
    s = 16'h3142;
    cycles(2);
    reset = 1'b0;
    for (int i = 0; i < 48; i++) begin
      s = lfsr(s);
      ctl = s[12:0] & 13'h1d3f;
      run_slot(s[13], s[14]);
    end
    ctl = 13'h0c3f;
    run_slot(1'b0, 1'b1);
    $display("test steering done");
    ctl = 13'h0200;
    hold_code(2'b10, 1'b1);
    auto_on = 1'b1;
    cycles(1);
    check_byte(status_reg0, 8'h80);
    run_slot(1'b1, 1'b0);
    hold_code(2'b01, 1'b0);
    auto_on = 1'b0;
    run_slot(1'b0, 1'b1);
    hold_code(2'b10, 1'b1);
    ctl[9] = 1'b0;
    cycles(1);
    check_bit(auto_loop_active_flag, 1'b0);
    check_bit(remote_active, 1'b0);
    // manual digital under a live auto remote loop must drop it
    ctl[9] = 1'b1;
    hold_code(2'b10, 1'b1);
    ctl[10] = 1'b1;
    cycles(1);
    check_bit(auto_loop_active_flag, 1'b0);
    check_bit(remote_active, 1'b0);
    check_bit(digital_active, 1'b1);
    ctl = 13'h0300;
    cycles(1);
    hold_code(2'b10, 1'b1);
    auto_on = 1'b1;
    check_bit(digital_active, 1'b1);
    ctl = 13'h0b3f;
    run_slot(1'b1, 1'b0);
    ctl = 13'h0300;
    hold_code(2'b01, 1'b0);
    auto_on = 1'b0;
    $display("test auto loop done");
    ctl = 13'h0680;
    cycles(HOLD + 3);
    check_bit(auto_loop_active_flag, 1'b0);
    ctl = 13'h1280;
    cycles(HOLD + 3);
    check_bit(auto_loop_active_flag, 1'b0);
    ctl = 13'h0000;
    $display("test refusals done");
    print_verdict();
  end

endmodule // llpc_line_loopback_tb_top
